// ===== logic/ssb_params.svh
// Register map, field positions, reset values and timing counts
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH
`define SSB_OFS_CTRL1     8'h00
`define SSB_OFS_CTRL2     8'h04
`define SSB_OFS_STATUS    8'h08
`define SSB_OFS_DATA      8'h0C
`define SSB_C1_RFIE       7
`define SSB_C1_TXIE       5
`define SSB_C1_MASTER_SELECT       4
`define SSB_C1_SELECT_OUTPUT_ENABLE       1
`define SSB_C2_FAULT_DETECT_ENABLE     4
`define SSB_ST_RF         7
`define SSB_ST_TE         5
`define SSB_ST_MF         4
`define SSB_C1_RST        8'h00
`define SSB_C2_RST        8'h00
`define SSB_SCK_HALF_DIV  4
`define SSB_RESP_OKAY     2'h0
`define SSB_RESP_SLVERR   2'h2
`endif

// ===== logic/ssb_pkg.sv
// Shared types of the serial status and data buffer block
`default_nettype none
package ssb_pkg;
    typedef enum logic [1:0] {
        SSB_ST_IDLE = 2'b01,
        SSB_ST_RUN  = 2'b10
    } ssb_state_type;
endpackage : ssb_pkg
`default_nettype wire

// ===== logic/ssb_shift_if.sv
// Link between buffer logic and the shift engine
`timescale 1ns/1ps
`default_nettype none
interface ssb_shift_if;
    logic       load;
    logic [7:0] load_byte;
    logic       master;
    logic       busy;
    logic       done;
    logic [7:0] rx_byte;
    modport ctl (output load, output load_byte, output master,
                 input busy, input done, input rx_byte);
    modport eng (input load, input load_byte, input master,
                 output busy, output done, output rx_byte);
endinterface : ssb_shift_if
`default_nettype wire

// ===== logic/ssb_shifter.sv
// Eight-bit shift engine, mode 0, master or slave
`timescale 1ns/1ps
`include "ssb_params.svh"
`default_nettype none
module ssb_shifter #(
    parameter int HALF_DIV = `SSB_SCK_HALF_DIV
) (
    input  wire logic  i_mclk,
    input  wire logic  i_rst_n,
    input  wire logic  i_ce,
    ssb_shift_if.eng   sif,
    input  wire logic  i_sck_s,
    input  wire logic  i_ss_n_s,
    input  wire logic  i_mosi_s,
    input  wire logic  i_miso_s,
    output var  logic  o_sck,
    output wire logic  o_sdo
);
    ssb_pkg::ssb_state_type state_q;
    logic [7:0]  sh_q;
    logic [7:0]  rx_q;
    logic [2:0]  cnt_q;
    logic [15:0] div_q;
    logic        samp_q;
    logic        prev_q;
    logic        done_q;

    wire div_end = (div_q == 16'(HALF_DIV - 1));
    wire m_run   = sif.master && (state_q == ssb_pkg::SSB_ST_RUN);
    wire rise    = sif.master ? (m_run && div_end && !o_sck)
                              : (!i_ss_n_s && i_sck_s && !prev_q);
    wire fall    = sif.master ? (m_run && div_end && o_sck)
                              : (!i_ss_n_s && !i_sck_s && prev_q);
    wire bit_in  = sif.master ? i_miso_s : i_mosi_s;
    wire last    = fall && (cnt_q == 3'h7);
    wire [7:0] sh_next = {sh_q[6:0], samp_q};

    assign sif.busy    = (state_q == ssb_pkg::SSB_ST_RUN);
    assign sif.done    = done_q;
    assign sif.rx_byte = rx_q;
    assign o_sdo       = sh_q[7];

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ssb_pkg::SSB_ST_IDLE;
            sh_q    <= 8'h00;
            rx_q    <= 8'h00;
            cnt_q   <= 3'h0;
            div_q   <= 16'h0000;
            samp_q  <= 1'b0;
            prev_q  <= 1'b0;
            done_q  <= 1'b0;
            o_sck   <= 1'b0;
        end else if (i_ce) begin
            prev_q <= i_sck_s;
            done_q <= last;
            div_q  <= (m_run && !div_end) ? div_q + 16'h0001 : 16'h0000;
            if (m_run && div_end) begin
                o_sck <= !o_sck;
            end
            if (!sif.master && i_ss_n_s) begin
                cnt_q <= 3'h0;
            end
            if (rise) begin
                samp_q <= bit_in;
            end
            if (fall) begin
                sh_q  <= sh_next;
                cnt_q <= cnt_q + 3'h1;
            end
            if (last) begin
                rx_q <= sh_next;
            end
            case (state_q)
                ssb_pkg::SSB_ST_IDLE: begin
                    if (sif.load) begin
                        sh_q    <= sif.load_byte;
                        cnt_q   <= 3'h0;
                        o_sck   <= 1'b0;
                        state_q <= ssb_pkg::SSB_ST_RUN;
                    end
                end
                ssb_pkg::SSB_ST_RUN: begin
                    if (last) begin
                        state_q <= ssb_pkg::SSB_ST_IDLE;
                    end
                end
                default: state_q <= ssb_pkg::SSB_ST_IDLE;
            endcase
        end
    end
endmodule : ssb_shifter
`default_nettype wire

// ===== logic/ssb_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssb_sync #(
    parameter int W = 4
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output var  logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : ssb_sync
`default_nettype wire

// ===== logic/ssb_top.sv
// Status flags, data buffers and register slave of the serial port
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "ssb_params.svh"
`default_nettype none
module ssb_top #(
    parameter int HALF_DIV = `SSB_SCK_HALF_DIV
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_ce,
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output wire logic        o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output wire logic        o_s_axi_wready,
    output var  logic [1:0]  o_s_axi_bresp,
    output var  logic        o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output wire logic        o_s_axi_arready,
    output var  logic [31:0] o_s_axi_rdata,
    output var  logic [1:0]  o_s_axi_rresp,
    output var  logic        o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready,
    input  wire logic        i_sck,
    output wire logic        o_sck,
    output wire logic        o_sck_oe,
    input  wire logic        i_mosi,
    output wire logic        o_mosi,
    output wire logic        o_mosi_oe,
    input  wire logic        i_miso,
    output wire logic        o_miso,
    output wire logic        o_miso_oe,
    input  wire logic        i_ss_n,
    output wire logic        o_ss_n,
    output wire logic        o_ss_n_oe,
    output var  logic        o_irq
);
    ssb_shift_if sif ();

    logic [7:0]  control_reg_one_q;
    logic [7:0]  ctrl2_q;
    logic [7:0]  txbuf_q;
    logic [7:0]  data_buffer_reg_q;
    logic        tx_full_q;
    logic        rx_full_flag_q;
    logic        mode_fault_flag_q;
    logic        te_seen_q;
    logic        rf_seen_q;
    logic        mf_seen_q;
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  awaddr_q;
    logic [7:0]  wdata_q;
    logic        wlane_q;
    logic [3:0]  pins_s;
    logic        sck_s;
    logic        ss_n_s;
    logic        mosi_s;
    logic        miso_s;
    logic        sck_out;
    logic        sdo;

    ssb_sync #(
        .W (4)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_async ({i_sck, ~i_ss_n, i_mosi, i_miso}),
        .o_sync  (pins_s)
    );
    // Select travels inverted so reset reads as deselected
    assign {sck_s, ss_n_s, mosi_s, miso_s} = pins_s ^ 4'b0100;

    ssb_shifter #(
        .HALF_DIV (HALF_DIV)
    ) u_shifter (
        .i_mclk   (i_mclk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .sif      (sif.eng),
        .i_sck_s  (sck_s),
        .i_ss_n_s (ss_n_s),
        .i_mosi_s (mosi_s),
        .i_miso_s (miso_s),
        .o_sck    (sck_out),
        .o_sdo    (sdo)
    );

    // Control fields
    wire master_select        = control_reg_one_q[`SSB_C1_MASTER_SELECT];
    wire tx_irq_enable        = control_reg_one_q[`SSB_C1_TXIE];
    wire rx_fault_irq_enable  = control_reg_one_q[`SSB_C1_RFIE];
    wire select_output_enable = control_reg_one_q[`SSB_C1_SELECT_OUTPUT_ENABLE];
    wire fault_detect_enable  = ctrl2_q[`SSB_C2_FAULT_DETECT_ENABLE];
    wire tx_empty_flag        = !tx_full_q;

    // Pins; slave drives its data line only while selected
    assign o_sck     = sck_out;
    assign o_sck_oe  = master_select;
    assign o_mosi    = sdo;
    assign o_mosi_oe = master_select;
    assign o_miso    = sdo;
    assign o_miso_oe = !master_select && !ss_n_s;
    assign o_ss_n    = !sif.busy;
    assign o_ss_n_oe = master_select && fault_detect_enable && select_output_enable;

    // Write channel: address and data taken in either order
    assign o_s_axi_awready = !aw_have_q && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_have_q && !o_s_axi_bvalid;
    wire aw_take  = i_s_axi_awvalid && o_s_axi_awready;
    wire w_take   = i_s_axi_wvalid && o_s_axi_wready;
    wire wr_fire  = aw_have_q && w_have_q && !o_s_axi_bvalid;
    wire wa_c1    = (awaddr_q == `SSB_OFS_CTRL1);
    wire wa_c2    = (awaddr_q == `SSB_OFS_CTRL2);
    wire wa_st    = (awaddr_q == `SSB_OFS_STATUS);
    wire wa_dat   = (awaddr_q == `SSB_OFS_DATA);
    wire wa_ok    = wa_c1 || wa_c2 || wa_st || wa_dat;
    wire wr_c1    = wr_fire && wa_c1;
    wire wr_c1_en = wr_c1 && wlane_q;
    wire wr_c2_en = wr_fire && wa_c2 && wlane_q;
    wire wr_dat   = wr_fire && wa_dat && wlane_q;

    // Read channel
    assign o_s_axi_arready = !o_s_axi_rvalid;
    wire rd_take = i_s_axi_arvalid && o_s_axi_arready;
    wire ra_c1   = (i_s_axi_araddr == `SSB_OFS_CTRL1);
    wire ra_c2   = (i_s_axi_araddr == `SSB_OFS_CTRL2);
    wire ra_st   = (i_s_axi_araddr == `SSB_OFS_STATUS);
    wire ra_dat  = (i_s_axi_araddr == `SSB_OFS_DATA);
    wire ra_ok   = ra_c1 || ra_c2 || ra_st || ra_dat;
    wire rd_st   = rd_take && ra_st;
    wire rd_dat  = rd_take && ra_dat;

    // Unimplemented status bits stay zero
    wire [7:0] status_reg = (8'(rx_full_flag_q) << `SSB_ST_RF)
                          | (8'(tx_empty_flag) << `SSB_ST_TE)
                          | (8'(mode_fault_flag_q) << `SSB_ST_MF);
    wire [7:0] rd_mux = ra_c1  ? control_reg_one_q :
                        ra_c2  ? ctrl2_q :
                        ra_st  ? status_reg :
                        ra_dat ? data_buffer_reg_q : 8'h00;

    // Transmit side
    wire tx_accept = wr_dat && te_seen_q;
    wire tx_move   = tx_full_q && !sif.busy;
    assign sif.load      = tx_move;
    assign sif.load_byte = txbuf_q;
    assign sif.master    = master_select;

    // Receive side; a full buffer drops the new byte
    wire rx_clear = rd_dat && rf_seen_q;
    wire rx_set   = sif.done && (!rx_full_flag_q || rx_clear);

    // Mode fault input only in one configuration
    wire fault_in = master_select && fault_detect_enable
                  && !select_output_enable && !ss_n_s;
    wire mf_clear = wr_c1 && mf_seen_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
        end else if (i_ce) begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata[7:0];
                wlane_q  <= i_s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= `SSB_RESP_OKAY;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rresp  <= `SSB_RESP_OKAY;
            o_s_axi_rdata  <= 32'h0000_0000;
        end else if (i_ce) begin
            if (wr_fire) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wa_ok ? `SSB_RESP_OKAY : `SSB_RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
            if (rd_take) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rresp  <= ra_ok ? `SSB_RESP_OKAY : `SSB_RESP_SLVERR;
                o_s_axi_rdata  <= {24'h00_0000, rd_mux};
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control_reg_one_q <= `SSB_C1_RST;
            ctrl2_q           <= `SSB_C2_RST;
        end else if (i_ce) begin
            if (wr_c1_en) begin
                control_reg_one_q <= wdata_q;
            end
            if (wr_c2_en) begin
                ctrl2_q <= wdata_q;
            end
        end
    end

    // Transmit buffer and its read-then-write arming
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_full_q <= 1'b0;
            txbuf_q   <= 8'h00;
            te_seen_q <= 1'b0;
        end else if (i_ce) begin
            if (tx_accept) begin
                tx_full_q <= 1'b1;
                txbuf_q   <= wdata_q;
            end else if (tx_move) begin
                tx_full_q <= 1'b0;
            end
            // Arming survives until the next data write, unless a status read in that cycle finds the buffer empty and re-arms it
            if (rd_st && tx_empty_flag) begin
                te_seen_q <= 1'b1;
            end else if (wr_dat) begin
                te_seen_q <= 1'b0;
            end
        end
    end

    // Receive buffer; a new byte wins over a same-cycle clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_full_flag_q    <= 1'b0;
            data_buffer_reg_q <= 8'h00;
            rf_seen_q         <= 1'b0;
        end else if (i_ce) begin
            if (rx_set) begin
                rx_full_flag_q    <= 1'b1;
                data_buffer_reg_q <= sif.rx_byte;
            end else if (rx_clear) begin
                rx_full_flag_q <= 1'b0;
            end
            if (rd_st && rx_full_flag_q) begin
                rf_seen_q <= 1'b1;
            end else if (rd_dat) begin
                rf_seen_q <= 1'b0;
            end
        end
    end

    // Mode fault; a persisting fault re-sets over a clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_fault_flag_q <= 1'b0;
            mf_seen_q         <= 1'b0;
        end else if (i_ce) begin
            if (fault_in) begin
                mode_fault_flag_q <= 1'b1;
            end else if (mf_clear) begin
                mode_fault_flag_q <= 1'b0;
            end
            if (rd_st && mode_fault_flag_q) begin
                mf_seen_q <= 1'b1;
            end else if (wr_c1) begin
                mf_seen_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= (tx_empty_flag && tx_irq_enable)
                   || ((rx_full_flag_q || mode_fault_flag_q)
                       && rx_fault_irq_enable);
        end
    end
endmodule : ssb_top
`default_nettype wire

// ===== test/spi_status_and_data_buffer_tb.sv
// Self-checking bench of the serial status and data buffer block
`timescale 1ns/1ps
`include "ssb_params.svh"
`default_nettype none
module spi_status_and_data_buffer_tb;
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1;
    logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0000_0000;
    logic [3:0]  i_s_axi_wstrb = 4'hF;
    logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic        i_sck = 1'b0, i_mosi = 1'b0, ss_drv = 1'b1, slow = 1'b0;
    logic [7:0]  tx_byte = 8'h00, b, b2, first, m_rx;
    logic [31:0] rdat, seed;
    logic [1:0]  resp;
    int          n_mismatch = 0, comparisons = 0, base, m_cnt;
    wire logic   o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    wire logic   o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, o_ss_n, o_ss_n_oe, o_irq;
    wire logic   i_miso;
    wire logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    wire logic [31:0] o_s_axi_rdata;
    wire logic   i_ss_n = o_ss_n_oe ? o_ss_n : ss_drv;
    always #20 i_mclk = ~i_mclk;
    ssb_top #(.HALF_DIV(4)) dut (.*);
    ssb_spi_slave_model peer (.i_sck(o_sck), .i_mosi(o_mosi), .i_sel_n(o_ss_n | ~o_sck_oe),
        .i_slow(slow), .i_tx_byte(tx_byte), .o_miso(i_miso), .o_rx_byte(m_rx), .o_rx_count(m_cnt));
    function automatic logic [31:0] st(input logic [2:0] f);
        st = {24'h00_0000, f[2], 1'b0, f[1:0], 4'h0};
    endfunction : st
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw = 1'b0, w = 1'b0;
        @(posedge i_mclk);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h00_0000, d};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge i_mclk);
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw = 1'b1;
                i_s_axi_awvalid <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w = 1'b1;
                i_s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge i_mclk); while (!o_s_axi_bvalid);
        resp = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do @(posedge i_mclk); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        do @(posedge i_mclk); while (!o_s_axi_rvalid);
        rdat = o_s_axi_rdata;
        resp = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wait_rx(input int n);
        for (int k = 0; k < 400 && m_cnt < n; k++) @(posedge i_mclk);
    endtask : wait_rx
    task automatic wait_rf;
        rd(`SSB_OFS_STATUS);
        for (int k = 0; k < 100 && !rdat[7]; k++) rd(`SSB_OFS_STATUS);
    endtask : wait_rf
    task automatic irq_is(input logic v);
        repeat (2) @(posedge i_mclk);
        check(32'(o_irq), 32'(v));
    endtask : irq_is
    task automatic pulse_ss;
        @(posedge i_mclk);
        ss_drv <= 1'b0;
        repeat (6) @(posedge i_mclk);
        ss_drv <= 1'b1;
        repeat (4) @(posedge i_mclk);
    endtask : pulse_ss
    // Link clock runs only inside the frame
    task automatic frame(input logic [7:0] v);
        ss_drv <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            i_mosi <= v[i];
            repeat (4) @(posedge i_mclk);
            i_sck <= 1'b1;
            repeat (4) @(posedge i_mclk);
            i_sck <= 1'b0;
        end
        repeat (4) @(posedge i_mclk);
        ss_drv <= 1'b1;
        repeat (8) @(posedge i_mclk);
    endtask : frame
    task automatic test_done;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    initial begin
        seed = $urandom(44419);
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b010));
        wr(`SSB_OFS_STATUS, 8'hFF);
        check(32'(resp), 32'(`SSB_RESP_OKAY));
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b010));
        rd(8'h10);
        check(32'(resp), 32'(`SSB_RESP_SLVERR));
        wr(`SSB_OFS_CTRL1, 8'h10);
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            tx_byte <= 8'($urandom);
            b = 8'($urandom);
            base = m_cnt;
            rd(`SSB_OFS_STATUS);
            check(rdat, st(3'b010));
            wr(`SSB_OFS_DATA, b);
            wait_rx(base + 1);
            check(32'(m_rx), 32'(b));
            wait_rf;
            rd(`SSB_OFS_DATA);
            check(rdat, 32'(tx_byte));
            rd(`SSB_OFS_STATUS);
            check(rdat, st(3'b010));
        end
        b = 8'($urandom);
        b2 = ~b;
        base = m_cnt;
        rd(`SSB_OFS_STATUS);
        wr(`SSB_OFS_DATA, b);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b010));
        wr(`SSB_OFS_DATA, b2);
        wr(`SSB_OFS_DATA, b);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b000));
        first = tx_byte;
        wait_rx(base + 1);
        tx_byte <= ~first;
        wait_rx(base + 2);
        check(32'(m_rx), 32'(b2));
        repeat (200) @(posedge i_mclk);
        check(32'(m_cnt), 32'(base + 2));
        rd(`SSB_OFS_DATA);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b110));
        rd(`SSB_OFS_DATA);
        check(rdat, 32'(first));
        rd(`SSB_OFS_STATUS);
        wr(`SSB_OFS_DATA, 8'($urandom));
        wait_rx(m_cnt + 1);
        repeat (12) @(posedge i_mclk);
        check(32'(o_irq), 32'h0000_0000);
        wr(`SSB_OFS_CTRL1, 8'h90);
        irq_is(1'b1);
        rd(`SSB_OFS_STATUS);
        rd(`SSB_OFS_DATA);
        irq_is(1'b0);
        wr(`SSB_OFS_CTRL1, 8'h30);
        irq_is(1'b1);
        wr(`SSB_OFS_CTRL1, 8'h10);
        irq_is(1'b0);
        pulse_ss;
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b010));
        wr(`SSB_OFS_CTRL2, 8'h10);
        pulse_ss;
        wr(`SSB_OFS_CTRL1, 8'h10);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b011));
        wr(`SSB_OFS_CTRL1, 8'h10);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b010));
        wr(`SSB_OFS_CTRL2, 8'h00);
        wr(`SSB_OFS_CTRL1, 8'h00);
        b = 8'($urandom);
        frame(b);
        frame(~b);
        rd(`SSB_OFS_STATUS);
        check(rdat, st(3'b110));
        rd(`SSB_OFS_DATA);
        check(rdat, 32'(b));
        test_done;
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done;
    end
endmodule : spi_status_and_data_buffer_tb
`default_nettype wire

// ===== test/ssb_spi_slave_model.sv
// Far-side serial device model, mode 0, most significant bit first
`timescale 1ns/1ps
`default_nettype none
module ssb_spi_slave_model (
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_sel_n,
    input  wire logic       i_slow,
    input  wire logic [7:0] i_tx_byte,
    output var  logic       o_miso,
    output var  logic [7:0] o_rx_byte,
    output var  int         o_rx_count
);
    logic [7:0] tx_q, rx_q;
    int         nbits;
    initial begin
        o_miso = 1'b0;
        o_rx_byte = 8'h00;
        o_rx_count = 0;
        nbits = 0;
    end
    always @(negedge i_sel_n) begin
        tx_q = i_tx_byte;
        nbits = 0;
        o_miso = tx_q[7];
    end
    // Released line shows the inverse, never a stale bit
    always @(posedge i_sel_n) o_miso = ~o_miso;
    always @(posedge i_sck) begin
        if (!i_sel_n) begin
            rx_q = {rx_q[6:0], i_mosi};
            nbits++;
            if (nbits == 8) begin
                o_rx_byte = rx_q;
                o_rx_count++;
            end
        end
    end
    always @(negedge i_sck) begin
        if (!i_sel_n) begin
            // Select may stay low between queued bytes
            if (nbits == 8) begin
                tx_q = i_tx_byte;
                nbits = 0;
            end else begin
                tx_q = {tx_q[6:0], 1'b0};
            end
            if (i_slow) o_miso <= #40 tx_q[7];
            else o_miso <= tx_q[7];
        end
    end
endmodule : ssb_spi_slave_model
`default_nettype wire

// ===== test/ssb_sva.sv
// Port-level checker of the serial status and data buffer block
`timescale 1ns/1ps
`include "ssb_params.svh"
`default_nettype none
module ssb_sva #(
    parameter int HALF_DIV = 4
) (
    input wire logic        i_mclk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_s_axi_awaddr,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic [1:0]  o_s_axi_bresp,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic [7:0]  i_s_axi_araddr,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic        o_sck,
    input wire logic        o_sck_oe,
    input wire logic        o_ss_n,
    input wire logic        o_ss_n_oe,
    input wire logic        o_irq
);
    localparam int SCK_WAIT = 2 * HALF_DIV;
    logic [7:0] aw_q, wd_q, ar_q, ctl_q;
    logic       bv_q, sck_q;
    logic [5:0] cnt_q;
    wire logic  irq_en = ctl_q[7] | ctl_q[5];
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_q  <= 8'h00;
            wd_q  <= 8'h00;
            ar_q  <= 8'h00;
            ctl_q <= 8'h00;
            bv_q  <= 1'b0;
            sck_q <= 1'b0;
            cnt_q <= 6'h00;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) aw_q <= i_s_axi_awaddr;
            if (i_s_axi_wvalid && o_s_axi_wready) wd_q <= i_s_axi_wdata[7:0];
            if (i_s_axi_arvalid && o_s_axi_arready) ar_q <= i_s_axi_araddr;
            if (o_s_axi_bvalid && !bv_q && aw_q == `SSB_OFS_CTRL1) ctl_q <= wd_q;
            bv_q  <= o_s_axi_bvalid;
            sck_q <= o_sck;
            cnt_q <= o_ss_n ? 6'h00 : cnt_q + {5'h00, o_sck & ~sck_q};
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    irq_gate_a: assert property (!irq_en && !$past(irq_en) |-> !o_irq)
        else $error("interrupt raised with both enables off");
    status_zero_a: assert property (o_s_axi_rvalid && ar_q == `SSB_OFS_STATUS |->
        o_s_axi_rdata[31:8] == 24'h00_0000 && !o_s_axi_rdata[6] && o_s_axi_rdata[3:0] == 4'h0)
        else $error("status read shows a reserved bit set");
    read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data dropped early");
    bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
        o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped early");
    write_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write accepted while answer pending");
    sck_idle_a: assert property (o_sck_oe && o_ss_n |-> !o_sck)
        else $error("serial clock moves outside a transfer");
    frame_bits_a: assert property ($rose(o_ss_n) && o_sck_oe |->
        cnt_q[2:0] == 3'h0 && cnt_q != 6'h00) else $error("frame not whole bytes");
    start_clock_a: assert property ($fell(o_ss_n) && o_sck_oe |-> ##[1:SCK_WAIT] $rose(o_sck))
        else $error("transfer started without clock");
    select_out_a: assert property (o_ss_n_oe |-> o_sck_oe)
        else $error("select driven outside master mode");
    cover property ($rose(o_ss_n) && o_sck_oe);
    cover property (o_s_axi_rvalid && ar_q == `SSB_OFS_STATUS && o_s_axi_rdata[7]);
    cover property (o_s_axi_rvalid && ar_q == `SSB_OFS_STATUS && o_s_axi_rdata[4]);
    cover property ($rose(o_irq));
endmodule : ssb_sva
bind ssb_top ssb_sva #(.HALF_DIV(HALF_DIV)) u_sva (.*);
`default_nettype wire
